// ==== core/sehp_consts.svh ====
`ifndef SEHP_CONSTS_SVH
`define SEHP_CONSTS_SVH

// Instruction opcodes
`define SEHP_WRITE_STATUS_OPCODE 8'h01
`define SEHP_WRITE_OPCODE 8'h02
`define SEHP_READ_OPCODE 8'h03
`define SEHP_WRITE_DISABLE_OPCODE 8'h04
`define SEHP_READ_STATUS_OPCODE 8'h05
`define SEHP_WRITE_ENABLE_OPCODE 8'h06

// Status register field positions
`define SEHP_ST_READY 0
`define SEHP_ST_LATCH_POS 1
`define SEHP_ST_BP0 2
`define SEHP_ST_BP1 3
`define SEHP_ST_LOCK 4
`define SEHP_ST_ID_SEL 6
`define SEHP_ST_WPEN 7

// Bits that a status write may change, and reset value of the stored bits
`define SEHP_ST_WRITE_MASK 8'hDC
`define SEHP_ST_RESET 8'h00

// Array address width, index of the last address byte, last bit of a byte
`define SEHP_ARRAY_AW 17
`define SEHP_LAST_ADDR_BYTE 2'h2
`define SEHP_LAST_BIT 3'h7

// Self-timed write cycle length in clock_i cycles
`define SEHP_WRITE_CYCLES_DEF 1000

`endif

// ==== core/sehp_link.sv ====
`include "sehp_consts.svh"

module sehp_link (
    input wire logic sck_i,
    input wire logic cs_n_i,
    input wire logic hold_n_i,
    input wire logic si_i,
    input wire logic [7:0] tx_byte_i,
    input wire logic tx_en_i,
    output logic so_o,
    output logic so_oe_o,
    output logic [7:0] rx_byte_o,
    output logic rx_tgl_o
);

    logic [2:0] bitcnt_ff;
    logic [2:0] nxt_bitcnt;
    logic [6:0] rxsh_ff;
    logic [6:0] nxt_rxsh;
    logic rx_tgl_ff;
    logic nxt_rx_tgl;
    logic seen_ff;
    logic nxt_seen;
    logic [7:0] rx_byte_ff;
    logic [7:0] nxt_rx_byte;
    logic [7:0] txsh_ff;
    logic [7:0] nxt_txsh;
    logic drv_ff;
    logic nxt_drv;

    // Rising edges shift SI in, MSB first; a paused link takes nothing
    always_comb begin
        nxt_bitcnt = bitcnt_ff;
        nxt_rxsh = rxsh_ff;
        nxt_rx_tgl = rx_tgl_ff;
        nxt_seen = seen_ff;
        nxt_rx_byte = rx_byte_ff;
        if (hold_n_i) begin
            nxt_rxsh = {rxsh_ff[5:0], si_i};
            nxt_bitcnt = bitcnt_ff + 3'h1;
            nxt_seen = 1'b1;
            if (bitcnt_ff == `SEHP_LAST_BIT) begin
                nxt_rx_byte = {rxsh_ff, si_i};
                nxt_rx_tgl = ~rx_tgl_ff;
            end
        end
    end

    // Deselect clears the frame state, since the link clock may stop after it
    always_ff @(posedge sck_i or posedge cs_n_i) begin
        if (cs_n_i) begin
            bitcnt_ff <= 3'h0;
            rxsh_ff <= 7'h00;
            rx_tgl_ff <= 1'b0;
            seen_ff <= 1'b0;
        end else begin
            bitcnt_ff <= nxt_bitcnt;
            rxsh_ff <= nxt_rxsh;
            rx_tgl_ff <= nxt_rx_tgl;
            seen_ff <= nxt_seen;
        end
    end

    // Received byte is held without reset so the last one survives deselect
    always_ff @(posedge sck_i) begin
        rx_byte_ff <= nxt_rx_byte;
    end

    // Falling edges load a new byte at each boundary, else shift out
    always_comb begin
        nxt_txsh = txsh_ff;
        nxt_drv = drv_ff;
        if (hold_n_i && seen_ff) begin
            if (bitcnt_ff == 3'h0) begin
                nxt_txsh = tx_byte_i;
                nxt_drv = tx_en_i;
            end else begin
                nxt_txsh = {txsh_ff[6:0], 1'b0};
            end
        end
    end

    always_ff @(negedge sck_i or posedge cs_n_i) begin
        if (cs_n_i) begin
            txsh_ff <= 8'h00;
            drv_ff <= 1'b0;
        end else begin
            txsh_ff <= nxt_txsh;
            drv_ff <= nxt_drv;
        end
    end

    // Pause and deselect float SO at once, without waiting for an edge
    assign so_o = txsh_ff[7];
    assign so_oe_o = drv_ff & hold_n_i & ~cs_n_i;
    assign rx_byte_o = rx_byte_ff;
    assign rx_tgl_o = rx_tgl_ff;

endmodule

// ==== core/sehp_pkg.sv ====
package sehp_pkg;

    // Phase of the current selection
    typedef enum logic [2:0] {
        SEHP_OPCODE = 3'b000,
        SEHP_ADDR = 3'b001,
        SEHP_READ = 3'b010,
        SEHP_WRITE = 3'b011,
        SEHP_WRSTAT = 3'b100,
        SEHP_STATUS = 3'b101,
        SEHP_IGNORE = 3'b110
    } sehp_state_type;

endpackage

// ==== core/sehp_port.sv ====
// What this block does
// - Addressed byte driven right after last address bit.
// - Pointer advances one per byte while selected.
// - Array pointer wraps from top to zero on reads.
// - Deselect ends the read and floats output.
// - ID page read uses low eight address bits.
// - ID page address increments within eight bits.
// - Status opcode returns status right after opcode.
// - Status read accepted even during write cycle.
// - During hold, output floats and input ignored.
// - After reset, write enable latch is clear.
// - First instruction only after select falls.
// - Completed write clears the write enable latch.
// - Write cycle starts when select rises.
// - Array access during write cycle is ignored.
// - Unknown opcode ignored, output stays floating.
// - Reset abandons any operation in progress.
// - Array uses only low seventeen address bits.
// - Ready bit is one during write cycle.
// - Page-select bit clears after read or write.
`include "sehp_consts.svh"

module sehp_port #(
    parameter int WRITE_CYCLES = `SEHP_WRITE_CYCLES_DEF
) (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic sck_i,
    input wire logic cs_n_i,
    input wire logic hold_n_i,
    input wire logic si_i,
    output logic so_o,
    output logic so_oe_o,
    output logic [`SEHP_ARRAY_AW-1:0] mem_addr_o,
    output logic mem_id_page_o,
    output logic mem_rd_o,
    input wire logic [7:0] mem_rdata_i,
    output logic mem_load_o,
    output logic [7:0] mem_wdata_o,
    output logic mem_commit_o,
    output logic [7:0] status_o,
    output logic write_busy_o
);

    localparam int AW = `SEHP_ARRAY_AW;

    logic [7:0] rx_byte;
    logic rx_tgl;
    logic cs_s1_ff;
    logic cs_s2_ff;
    logic cs_s3_ff;
    logic [3:0] tgl_s_ff;
    logic ev;
    logic cs_rise;
    logic cs_fall;
    logic [7:0] status_w;
    logic [AW-1:0] addr_inc;
    logic [AW-1:0] page_inc;

    sehp_pkg::sehp_state_type state_ff;
    sehp_pkg::sehp_state_type nxt_state;
    logic [1:0] abyte_ff;
    logic [1:0] nxt_abyte;
    logic [AW-1:0] addr_ff;
    logic [AW-1:0] nxt_addr;
    logic is_write_ff;
    logic nxt_is_write;
    logic ip_mode_ff;
    logic nxt_ip_mode;
    logic [7:0] tx_byte_ff;
    logic [7:0] nxt_tx_byte;
    logic tx_en_ff;
    logic nxt_tx_en;
    logic mem_rd_ff;
    logic nxt_mem_rd;
    logic rd_lat_ff;
    logic nxt_rd_lat;
    logic load_ff;
    logic nxt_load;
    logic [7:0] wdata_ff;
    logic [7:0] nxt_wdata;
    logic commit_ff;
    logic nxt_commit;
    logic wr_any_ff;
    logic nxt_wr_any;
    logic wrsr_ok_ff;
    logic nxt_wrsr_ok;
    logic [7:0] wrsr_val_ff;
    logic [7:0] nxt_wrsr_val;
    logic we_set_ff;
    logic nxt_we_set;
    logic we_clr_ff;
    logic nxt_we_clr;
    logic ip_used_ff;
    logic nxt_ip_used;
    logic busy_ff;
    logic nxt_busy;
    logic [15:0] wcnt_ff;
    logic [15:0] nxt_wcnt;
    logic wr_ip_ff;
    logic nxt_wr_ip;
    logic write_enable_latch_ff;
    logic nxt_write_enable_latch;
    logic [7:0] stat_ff;
    logic [7:0] nxt_stat;
    logic armed_ff;
    logic nxt_armed;

    // Serial shifter running in the link clock domain
    sehp_link u_link (
        .sck_i(sck_i),
        .cs_n_i(cs_n_i),
        .hold_n_i(hold_n_i),
        .si_i(si_i),
        .tx_byte_i(tx_byte_ff),
        .tx_en_i(tx_en_ff),
        .so_o(so_o),
        .so_oe_o(so_oe_o),
        .rx_byte_o(rx_byte),
        .rx_tgl_o(rx_tgl)
    );

    // Select level crosses over two flip-flops, byte toggle over three
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            cs_s1_ff <= 1'b1;
            cs_s2_ff <= 1'b1;
            cs_s3_ff <= 1'b1;
            tgl_s_ff <= 4'h0;
        end else begin
            cs_s1_ff <= cs_n_i;
            cs_s2_ff <= cs_s1_ff;
            cs_s3_ff <= cs_s2_ff;
            tgl_s_ff <= {tgl_s_ff[2:0], rx_tgl};
        end
    end

    // The toggle clears with deselect; one extra stage lets select mask it
    assign ev = (tgl_s_ff[2] ^ tgl_s_ff[3]) & ~cs_s2_ff & armed_ff;
    assign cs_rise = cs_s2_ff & ~cs_s3_ff;
    assign cs_fall = ~cs_s2_ff & cs_s3_ff;

    assign status_w = stat_ff | {6'h00, write_enable_latch_ff, busy_ff};
    assign addr_inc = ip_mode_ff ? {addr_ff[AW-1:8], addr_ff[7:0] + 8'h01}
                                 : addr_ff + 17'h00001;
    assign page_inc = {addr_ff[AW-1:8], addr_ff[7:0] + 8'h01};

    // Command sequencing, pointer, status and write cycle
    always_comb begin
        nxt_state = state_ff;
        nxt_abyte = abyte_ff;
        nxt_addr = addr_ff;
        nxt_is_write = is_write_ff;
        nxt_ip_mode = ip_mode_ff;
        nxt_tx_byte = tx_byte_ff;
        nxt_tx_en = tx_en_ff;
        nxt_mem_rd = 1'b0;
        nxt_rd_lat = mem_rd_ff;
        nxt_load = 1'b0;
        nxt_wdata = wdata_ff;
        nxt_commit = 1'b0;
        nxt_wr_any = wr_any_ff;
        nxt_wrsr_ok = wrsr_ok_ff;
        nxt_wrsr_val = wrsr_val_ff;
        nxt_we_set = we_set_ff;
        nxt_we_clr = we_clr_ff;
        nxt_ip_used = ip_used_ff;
        nxt_busy = busy_ff;
        nxt_wcnt = wcnt_ff;
        nxt_wr_ip = wr_ip_ff;
        nxt_write_enable_latch = write_enable_latch_ff;
        nxt_stat = stat_ff;
        nxt_armed = armed_ff | cs_fall;
        // Read data lands one cycle after the strobe, then the pointer moves
        if (rd_lat_ff) begin
            nxt_tx_byte = mem_rdata_i;
            nxt_tx_en = 1'b1;
            nxt_addr = addr_inc;
            nxt_ip_used = ip_mode_ff;
        end
        // Page loading rolls over inside the page
        if (load_ff) begin
            nxt_addr = page_inc;
        end
        // Self-timed write cycle countdown
        if (busy_ff) begin
            nxt_wcnt = wcnt_ff - 16'h0001;
            if (wcnt_ff == 16'h0001) begin
                nxt_busy = 1'b0;
                nxt_write_enable_latch = 1'b0;
                if (wr_ip_ff) begin
                    nxt_stat[`SEHP_ST_ID_SEL] = 1'b0;
                end
            end
        end
        if (ev) begin
            unique case (state_ff)
                sehp_pkg::SEHP_OPCODE: begin
                    nxt_state = sehp_pkg::SEHP_IGNORE;
                    case (rx_byte)
                        `SEHP_READ_OPCODE: begin
                            if (!busy_ff) begin
                                nxt_state = sehp_pkg::SEHP_ADDR;
                                nxt_is_write = 1'b0;
                                nxt_ip_mode = stat_ff[`SEHP_ST_ID_SEL];
                            end
                        end
                        `SEHP_WRITE_OPCODE: begin
                            // Locked ID page refuses writes
                            if (!busy_ff && write_enable_latch_ff &&
                                !(stat_ff[`SEHP_ST_ID_SEL] && stat_ff[`SEHP_ST_LOCK])) begin
                                nxt_state = sehp_pkg::SEHP_ADDR;
                                nxt_is_write = 1'b1;
                                nxt_ip_mode = stat_ff[`SEHP_ST_ID_SEL];
                            end
                        end
                        `SEHP_READ_STATUS_OPCODE: begin
                            nxt_state = sehp_pkg::SEHP_STATUS;
                            nxt_tx_byte = status_w;
                            nxt_tx_en = 1'b1;
                        end
                        `SEHP_WRITE_ENABLE_OPCODE: begin
                            nxt_we_set = ~busy_ff;
                            nxt_we_clr = 1'b0;
                        end
                        `SEHP_WRITE_DISABLE_OPCODE: begin
                            nxt_we_clr = ~busy_ff;
                            nxt_we_set = 1'b0;
                        end
                        `SEHP_WRITE_STATUS_OPCODE: begin
                            if (!busy_ff && write_enable_latch_ff) begin
                                nxt_state = sehp_pkg::SEHP_WRSTAT;
                            end
                        end
                        default: begin
                            nxt_state = sehp_pkg::SEHP_IGNORE;
                        end
                    endcase
                end
                sehp_pkg::SEHP_ADDR: begin
                    // Only the low address bits are kept
                    nxt_addr = {addr_ff[AW-9:0], rx_byte};
                    nxt_abyte = abyte_ff + 2'h1;
                    if (abyte_ff == `SEHP_LAST_ADDR_BYTE) begin
                        if (is_write_ff) begin
                            nxt_state = sehp_pkg::SEHP_WRITE;
                        end else begin
                            nxt_state = sehp_pkg::SEHP_READ;
                            nxt_mem_rd = 1'b1;
                        end
                    end
                end
                sehp_pkg::SEHP_READ: begin
                    nxt_mem_rd = 1'b1;
                end
                sehp_pkg::SEHP_WRITE: begin
                    nxt_load = 1'b1;
                    nxt_wdata = rx_byte;
                    nxt_wr_any = 1'b1;
                end
                sehp_pkg::SEHP_WRSTAT: begin
                    nxt_wrsr_val = rx_byte;
                    nxt_wrsr_ok = 1'b1;
                    nxt_state = sehp_pkg::SEHP_IGNORE;
                end
                sehp_pkg::SEHP_STATUS: begin
                    nxt_tx_byte = status_w;
                end
                sehp_pkg::SEHP_IGNORE: begin
                    // A status write with trailing bytes is not a clean write
                    nxt_wrsr_ok = 1'b0;
                end
                default: begin
                    nxt_state = sehp_pkg::SEHP_IGNORE;
                end
            endcase
        end
        // Deselect closes the frame and launches any pending write
        if (cs_rise) begin
            nxt_state = sehp_pkg::SEHP_OPCODE;
            nxt_abyte = 2'h0;
            nxt_tx_en = 1'b0;
            nxt_wr_any = 1'b0;
            nxt_wrsr_ok = 1'b0;
            nxt_we_set = 1'b0;
            nxt_we_clr = 1'b0;
            nxt_ip_used = 1'b0;
            if (we_set_ff) begin
                nxt_write_enable_latch = 1'b1;
            end
            if (we_clr_ff) begin
                nxt_write_enable_latch = 1'b0;
            end
            if (wr_any_ff) begin
                nxt_commit = 1'b1;
                nxt_busy = 1'b1;
                nxt_wcnt = 16'(WRITE_CYCLES);
                nxt_wr_ip = ip_mode_ff;
            end
            if (wrsr_ok_ff) begin
                nxt_busy = 1'b1;
                nxt_wcnt = 16'(WRITE_CYCLES);
                nxt_wr_ip = 1'b0;
                nxt_stat = (stat_ff & ~`SEHP_ST_WRITE_MASK) |
                           (wrsr_val_ff & `SEHP_ST_WRITE_MASK);
                // Setting page select and lock together changes neither
                if (wrsr_val_ff[`SEHP_ST_ID_SEL] && wrsr_val_ff[`SEHP_ST_LOCK]) begin
                    nxt_stat[`SEHP_ST_ID_SEL] = stat_ff[`SEHP_ST_ID_SEL];
                    nxt_stat[`SEHP_ST_LOCK] = stat_ff[`SEHP_ST_LOCK];
                end
            end
            if (ip_used_ff) begin
                nxt_stat[`SEHP_ST_ID_SEL] = 1'b0;
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            state_ff <= sehp_pkg::SEHP_OPCODE;
            abyte_ff <= 2'h0;
            addr_ff <= 17'h00000;
            is_write_ff <= 1'b0;
            ip_mode_ff <= 1'b0;
            tx_byte_ff <= 8'h00;
            tx_en_ff <= 1'b0;
            mem_rd_ff <= 1'b0;
            rd_lat_ff <= 1'b0;
            load_ff <= 1'b0;
            wdata_ff <= 8'h00;
            commit_ff <= 1'b0;
            wr_any_ff <= 1'b0;
            wrsr_ok_ff <= 1'b0;
            wrsr_val_ff <= 8'h00;
            we_set_ff <= 1'b0;
            we_clr_ff <= 1'b0;
            ip_used_ff <= 1'b0;
            busy_ff <= 1'b0;
            wcnt_ff <= 16'h0000;
            wr_ip_ff <= 1'b0;
            write_enable_latch_ff <= 1'b0;
            stat_ff <= `SEHP_ST_RESET;
            armed_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            abyte_ff <= nxt_abyte;
            addr_ff <= nxt_addr;
            is_write_ff <= nxt_is_write;
            ip_mode_ff <= nxt_ip_mode;
            tx_byte_ff <= nxt_tx_byte;
            tx_en_ff <= nxt_tx_en;
            mem_rd_ff <= nxt_mem_rd;
            rd_lat_ff <= nxt_rd_lat;
            load_ff <= nxt_load;
            wdata_ff <= nxt_wdata;
            commit_ff <= nxt_commit;
            wr_any_ff <= nxt_wr_any;
            wrsr_ok_ff <= nxt_wrsr_ok;
            wrsr_val_ff <= nxt_wrsr_val;
            we_set_ff <= nxt_we_set;
            we_clr_ff <= nxt_we_clr;
            ip_used_ff <= nxt_ip_used;
            busy_ff <= nxt_busy;
            wcnt_ff <= nxt_wcnt;
            wr_ip_ff <= nxt_wr_ip;
            write_enable_latch_ff <= nxt_write_enable_latch;
            stat_ff <= nxt_stat;
            armed_ff <= nxt_armed;
        end
    end

    // ID page accesses present only the in-page offset
    assign mem_addr_o = ip_mode_ff ? {9'h000, addr_ff[7:0]} : addr_ff;
    assign mem_id_page_o = ip_mode_ff;
    assign mem_rd_o = mem_rd_ff;
    assign mem_load_o = load_ff;
    assign mem_wdata_o = wdata_ff;
    assign mem_commit_o = commit_ff;
    assign status_o = status_w;
    assign write_busy_o = busy_ff;

endmodule

// ==== dv/sehp_host.sv ====
module sehp_host (
    output logic sck_o,
    output logic cs_n_o,
    output logic hold_n_o,
    output logic si_o,
    input wire logic so_i,
    input wire logic so_oe_i
);
    timeunit 1ns;
    timeprecision 100ps;
    logic oe_seen;
    logic oe_hold;

    // Clock idles low between frames, select and pause idle high
    initial begin
        sck_o = 1'b0;
        cs_n_o = 1'b1;
        hold_n_o = 1'b1;
        si_o = 1'b0;
        oe_seen = 1'b0;
        oe_hold = 1'b0;
    end
    // Any driven bit in a frame is remembered for refusal checks
    always @(posedge sck_o) begin
        if (so_oe_i) oe_seen = 1'b1;
    end

    // Odd delay keeps the link unrelated in phase to the core clock
    task sel;
        #37 cs_n_o = 1'b0;
        oe_seen = 1'b0;
        #40;
    endtask
    // Data set up mid-low phase, reply taken at the rising edge
    task xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            si_o = tx[i];
            #20 sck_o = 1'b1;
            rx[i] = so_i;
            #40 sck_o = 1'b0;
            #20;
        end
    endtask
    // Released data line shows the inverse so stale values cannot pass
    task desel;
        #40 cs_n_o = 1'b1;
        si_o = ~si_o;
        #203;
    endtask
    // Pause with clock low, junk clocks and data meanwhile
    task pause;
        hold_n_o = 1'b0;
        oe_hold = 1'b0;
        repeat (2) begin
            si_o = ~si_o;
            #20 sck_o = 1'b1;
            if (so_oe_i) oe_hold = 1'b1;
            #40 sck_o = 1'b0;
            #20;
        end
        hold_n_o = 1'b1;
        #20;
    endtask
endmodule

// ==== dv/sehp_port_assertions.sv ====
module sehp_port_assertions #(
    parameter int WRITE_CYCLES = 1000
) (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic sck_i,
    input wire logic cs_n_i,
    input wire logic hold_n_i,
    input wire logic si_i,
    input wire logic so_o,
    input wire logic so_oe_o,
    input wire logic [16:0] mem_addr_o,
    input wire logic mem_id_page_o,
    input wire logic mem_rd_o,
    input wire logic [7:0] mem_rdata_i,
    input wire logic mem_load_o,
    input wire logic [7:0] mem_wdata_o,
    input wire logic mem_commit_o,
    input wire logic [7:0] status_o,
    input wire logic write_busy_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [15:0] busy_cnt_ff;
    logic [15:0] nxt_busy_cnt;

    // Length of the running write cycle, so its end can be judged to within one cycle
    always_comb begin
        nxt_busy_cnt = write_busy_o ? busy_cnt_ff + 16'h0001 : 16'h0000;
    end
    always_ff @(posedge clock_i) begin
        busy_cnt_ff <= rst_i ? 16'h0000 : nxt_busy_cnt;
    end

    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (rst_i);

    // Address holds one cycle after a strobe, then steps by one
    sequence s_addr_step;
        ##1 $stable(mem_addr_o) ##1 (mem_addr_o == $past(mem_addr_o, 2) + 17'h00001);
    endsequence
    // In-page pointer keeps the upper bits clear and rolls over in eight bits
    sequence s_page_step;
        ##1 $stable(mem_addr_o)
        ##1 (mem_addr_o == {9'h000, $past(mem_addr_o[7:0], 2) + 8'h01});
    endsequence
    // Self-timed cycle follows the commit within a few cycles
    sequence s_cycle_start;
        ##[0:3] write_busy_o;
    endsequence

    a_rd_advance: assert property (mem_rd_o && !mem_id_page_o |-> s_addr_step)
        else $error("array pointer did not step after a read");
    a_oe_select: assert property (so_oe_o |-> !cs_n_i)
        else $error("output driven while deselected");
    a_hold_float: assert property (!hold_n_i |-> !so_oe_o)
        else $error("output driven during pause");
    a_ready_busy: assert property ($stable(write_busy_o) |-> status_o[0] == write_busy_o)
        else $error("ready bit disagrees with write cycle");
    a_commit_busy: assert property (mem_commit_o |-> s_cycle_start)
        else $error("commit not followed by write cycle");
    a_busy_len: assert property ($fell(write_busy_o) |->
        busy_cnt_ff >= WRITE_CYCLES - 1 && busy_cnt_ff <= WRITE_CYCLES + 1)
        else $error("write cycle length wrong");
    a_wel_clear: assert property ($fell(write_busy_o) |-> !status_o[1])
        else $error("write enable latch kept after write");
    a_busy_quiet: assert property (write_busy_o |-> !mem_rd_o && !mem_load_o)
        else $error("array accessed during write cycle");
    a_id_upper: assert property (mem_rd_o && mem_id_page_o |-> s_page_step)
        else $error("page read with upper address bits set");
endmodule

// ==== dv/sehp_port_tb.sv ====
`include "sehp_consts.svh"
`define CHK(nm, e, a) chk(nm, (a) === (e), e, a)

module sehp_port_tb;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int WCYC = 2500;
    logic clock_i = 1'b0;
    logic rst_i = 1'b1;
    logic sck_i, cs_n_i, hold_n_i, si_i, so_o, so_oe_o;
    logic [16:0] mem_addr_o;
    logic mem_id_page_o, mem_rd_o, mem_load_o, mem_commit_o, write_busy_o;
    logic [7:0] mem_rdata_i = 8'h00;
    logic [7:0] mem_wdata_o, status_o, r8;
    int err_total = 0;
    int num_checks = 0;

    always #2 clock_i = ~clock_i;

    sehp_host host (.sck_o(sck_i), .cs_n_o(cs_n_i), .hold_n_o(hold_n_i), .si_o(si_i),
        .so_i(so_o), .so_oe_i(so_oe_o));
    sehp_port #(.WRITE_CYCLES(WCYC)) dut (.clock_i(clock_i), .rst_i(rst_i), .sck_i(sck_i),
        .cs_n_i(cs_n_i), .hold_n_i(hold_n_i), .si_i(si_i), .so_o(so_o), .so_oe_o(so_oe_o),
        .mem_addr_o(mem_addr_o), .mem_id_page_o(mem_id_page_o), .mem_rd_o(mem_rd_o),
        .mem_rdata_i(mem_rdata_i), .mem_load_o(mem_load_o), .mem_wdata_o(mem_wdata_o),
        .mem_commit_o(mem_commit_o), .status_o(status_o), .write_busy_o(write_busy_o));

    // Contents differ at every address near the wrap point
    function automatic logic [7:0] mdat(input logic [16:0] a, input logic id);
        return id ? ~a[7:0] : a[7:0] + a[15:8] + {a[16], 7'h00};
    endfunction
    // Memory answers the cycle after each read strobe
    always @(posedge clock_i) begin
        if (mem_rd_o) mem_rdata_i <= mdat(mem_addr_o, mem_id_page_o);
    end

    task stop_test;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task chk(input string nm, input bit ok, input logic [23:0] e, input logic [23:0] g);
        num_checks++;
        if (!ok) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task do_reset;
        @(posedge clock_i);
        rst_i <= 1'b1;
        repeat (3) @(posedge clock_i);
        rst_i <= 1'b0;
        repeat (8) @(posedge clock_i);
    endtask
    // Bounded wait for the self-timed cycle to finish
    task wait_idle;
        int n;
        n = 0;
        while (write_busy_o !== 1'b0 && n < 4000) begin
            @(posedge clock_i);
            n++;
        end
        if (n >= 4000) begin
            err_total++;
            stop_test();
        end
    endtask
    task op(input logic [7:0] c, input int nb, input logic [7:0] d);
        host.sel();
        host.xfer(c, r8);
        for (int i = 0; i < nb; i++) host.xfer(d, r8);
        host.desel();
    endtask
    // Read frame with a running expectation; optional pause after the first byte
    task rd_chk(input logic [23:0] a, input int n, input logic id, input bit hld);
        logic [16:0] p;
        p = id ? {9'h000, a[7:0]} : a[16:0];
        host.sel();
        host.xfer(`SEHP_READ_OPCODE, r8);
        for (int i = 2; i >= 0; i--) host.xfer(a[8*i +: 8], r8);
        for (int i = 0; i < n; i++) begin
            if (hld && i == 1) host.pause();
            host.xfer(8'h00, r8);
            `CHK("read byte", mdat(p, id), r8);
            p = id ? {9'h000, p[7:0] + 8'h01} : p + 17'h00001;
        end
        host.desel();
        `CHK("oe after frame", 1'b0, so_oe_o);
    endtask

    task t_power;
        `CHK("status", 8'h00, status_o);
        `CHK("busy", 1'b0, write_busy_o);
        `CHK("oe", 1'b0, so_oe_o);
        $display("test power done");
    endtask
    task t_read;
        rd_chk(24'h3FFFFE, 4, 1'b0, 1'b0);
        rd_chk(24'hFE0123, 3, 1'b0, 1'b1);
        `CHK("oe in pause", 1'b0, host.oe_hold);
        $display("test read done");
    endtask
    task t_busy;
        op(`SEHP_WRITE_ENABLE_OPCODE, 0, 8'h00);
        `CHK("latch set", 8'h02, status_o);
        host.sel();
        host.xfer(`SEHP_WRITE_OPCODE, r8);
        for (int i = 0; i < 3; i++) host.xfer(8'h10, r8);
        host.xfer(8'hA5, r8);
        host.desel();
        `CHK("busy", 1'b1, write_busy_o);
        `CHK("wdata", 8'hA5, mem_wdata_o);
        op(`SEHP_READ_OPCODE, 4, 8'h00);
        `CHK("read in cycle", 1'b0, host.oe_seen);
        op(`SEHP_READ_STATUS_OPCODE, 1, 8'h00);
        `CHK("status in cycle", 2'b11, r8[1:0]);
        wait_idle();
        `CHK("status after", 8'h00, status_o);
        $display("test busy done");
    endtask
    task t_idpage;
        op(`SEHP_WRITE_ENABLE_OPCODE, 0, 8'h00);
        op(`SEHP_WRITE_STATUS_OPCODE, 1, 8'h40);
        wait_idle();
        `CHK("page select", 8'h40, status_o);
        rd_chk(24'hABCDFE, 2, 1'b1, 1'b0);
        `CHK("select cleared", 8'h00, status_o);
        $display("test page done");
    endtask
    task t_badop;
        op(8'hFF, 4, 8'h00);
        `CHK("bad opcode oe", 1'b0, host.oe_seen);
        op(`SEHP_WRITE_ENABLE_OPCODE, 0, 8'h00);
        op(`SEHP_WRITE_DISABLE_OPCODE, 0, 8'h00);
        `CHK("latch off", 8'h00, status_o);
        op(`SEHP_WRITE_OPCODE, 4, 8'h00);
        `CHK("write refused", 1'b0, write_busy_o);
        rd_chk(24'h000005, 1, 1'b0, 1'b0);
        $display("test opcode done");
    endtask
    task t_reset_mid;
        op(`SEHP_WRITE_ENABLE_OPCODE, 0, 8'h00);
        op(`SEHP_WRITE_OPCODE, 4, 8'h3C);
        `CHK("busy before", 1'b1, write_busy_o);
        do_reset();
        `CHK("busy abandoned", 1'b0, write_busy_o);
        `CHK("status reset", 8'h00, status_o);
        rd_chk(24'h01FFFF, 2, 1'b0, 1'b0);
        $display("test reset done");
    endtask

    initial begin
        do_reset();
        t_power();
        t_read();
        t_busy();
        t_idpage();
        t_badop();
        t_reset_mid();
        stop_test();
    end
endmodule

bind sehp_port sehp_port_assertions #(.WRITE_CYCLES(WRITE_CYCLES)) u_chk (
    .clock_i(clock_i), .rst_i(rst_i), .sck_i(sck_i), .cs_n_i(cs_n_i), .hold_n_i(hold_n_i),
    .si_i(si_i), .so_o(so_o), .so_oe_o(so_oe_o), .mem_addr_o(mem_addr_o),
    .mem_id_page_o(mem_id_page_o), .mem_rd_o(mem_rd_o), .mem_rdata_i(mem_rdata_i),
    .mem_load_o(mem_load_o), .mem_wdata_o(mem_wdata_o), .mem_commit_o(mem_commit_o),
    .status_o(status_o), .write_busy_o(write_busy_o));
